//--- src/sacc_pkg.sv
package sacc_pkg;

	// Register addresses on the special function register port
	localparam logic [7:0] CFG_ADDR  = 8'hbc;
	localparam logic [7:0] CTRL_ADDR = 8'he8;

	// Control register field positions
	localparam int CTRL_ON_BIT    = 7;
	localparam int CTRL_BURST_BIT = 6;
	localparam int CTRL_DONE_BIT  = 5;
	localparam int CTRL_BUSY_BIT  = 4;
	localparam int CTRL_WIN_BIT   = 3;
	localparam int CTRL_SRC_LSB   = 0;

	// Configuration register field positions
	localparam int CFG_DIV_LSB   = 3;
	localparam int CFG_EIGHT_BIT = 2;
	localparam int CFG_TRACK_BIT = 1;
	localparam int CFG_GAIN_BIT  = 0;

	// Values after reset
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET  = 8'hf9;

	// Start source encodings
	localparam logic [2:0] SRC_SOFTWARE = 3'h0;
	localparam logic [2:0] SRC_TIMER0   = 3'h1;
	localparam logic [2:0] SRC_TIMER2   = 3'h2;
	localparam logic [2:0] SRC_TIMER3   = 3'h3;

	// Clock rates and the low-power oscillator prescale
	localparam int SYS_CLK_MHZ = 200;
	localparam int LPO_CLK_MHZ = 20;
	localparam logic [3:0] LPO_LAST = 4'(SYS_CLK_MHZ / LPO_CLK_MHZ - 1);

	// Counts in SAR clocks
	localparam logic [3:0] TRACK_CLKS   = 4'h3;
	localparam logic [3:0] CONV_CLKS_10 = 4'hd;
	localparam logic [3:0] CONV_CLKS_8  = 4'hb;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TRACK,
		ST_CONV
	} sacc_state_e;

endpackage

//--- src/sacc_div_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sacc_div_if;
	logic       burst;
	logic [4:0] div;
	logic       run;
	logic       sar_tick;

	modport core (output burst, output div, output run, input sar_tick);
	modport div_end (input burst, input div, input run, output sar_tick);
endinterface // sacc_div_if

`default_nettype wire

//--- src/sacc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_pin_sync (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// Pin and its rising edge
	input  wire logic pin_i,
	output logic      rise_o
);

	logic s1_q, s2_q, s3_q, stable_q, rise_q;
	logic stable_d, rise_d;

	// Edge counts only once stages two and three agree
	always_comb begin
		stable_d = (s2_q == s3_q) ? s2_q : stable_q;
		rise_d   = (s2_q == s3_q) && s2_q && !stable_q;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s1_q     <= 1'b0;
			s2_q     <= 1'b0;
			s3_q     <= 1'b0;
			stable_q <= 1'b0;
			rise_q   <= 1'b0;
		end else begin
			s1_q     <= pin_i;
			s2_q     <= s1_q;
			s3_q     <= s2_q;
			stable_q <= stable_d;
			rise_q   <= rise_d;
		end
	end

	assign rise_o = rise_q;

endmodule // sacc_pin_sync

`default_nettype wire

//--- src/sacc_divider.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_divider import sacc_pkg::*; (
	// Clock and reset
	input  wire logic  clk_i,
	input  wire logic  srst_i,
	// Link to the core
	sacc_div_if.div_end div_if
);

	logic [3:0] lpo_cnt_q, lpo_cnt_d;
	logic [4:0] src_cnt_q, src_cnt_d;
	logic       tick_q, tick_d;
	logic       lpo_tick, src_en;

	always_comb begin
		lpo_tick  = (lpo_cnt_q == LPO_LAST);
		lpo_cnt_d = lpo_tick ? 4'h0 : lpo_cnt_q + 4'h1;
		src_en    = div_if.burst ? lpo_tick : 1'b1;
		src_cnt_d = src_cnt_q;
		tick_d    = 1'b0;
		if (!div_if.run) begin
			src_cnt_d = 5'h00;
		end else if (src_en) begin
			if (src_cnt_q == div_if.div) begin
				src_cnt_d = 5'h00;
				tick_d    = 1'b1;
			end else begin
				src_cnt_d = src_cnt_q + 5'h01;
			end
		end
	end

	// Prescaler runs free so the oscillator phase is independent
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lpo_cnt_q <= 4'h0;
			src_cnt_q <= 5'h00;
			tick_q    <= 1'b0;
		end else begin
			lpo_cnt_q <= lpo_cnt_d;
			src_cnt_q <= src_cnt_d;
			tick_q    <= tick_d;
		end
	end

	assign div_if.sar_tick = tick_q;

endmodule // sacc_divider

`default_nettype wire

//--- src/sacc_core.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Enable bit clear means converter shut down
// - Control bit six selects burst operation
// - Done flag set per conversion or burst
// - Busy write starts conversion when source software
// - Window flag set when result inside bounds
// - Source field picks software, timers or pin
// - SAR clock is source over divider plus one
// - Source is system clock, or oscillator in burst
// - Normal tracking converts right after start
// - Delayed tracking waits three SAR clocks first
// - Eight-bit mode: two clocks shorter, low zero
// - Gain bit picks unity or half gain
module sacc_core import sacc_pkg::*; (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	// Special function register port
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_wr_i,
	input  wire logic [7:0] sfr_wdata_i,
	output logic      [7:0] sfr_rdata_o,
	// Start sources
	input  wire logic       timer0_ovf_i,
	input  wire logic       timer2_ovf_i,
	input  wire logic       timer3_ovf_i,
	input  wire logic       external_convert_pin_i,
	// Analog front end
	input  wire logic [9:0] sample_data_i,
	output logic            converter_on_o,
	output logic            tracking_o,
	output logic            input_gain_select_o,
	output logic            burst_sequence_on_o,
	// Window bounds
	input  wire logic [15:0] window_lower_bound_i,
	input  wire logic [15:0] window_upper_bound_i,
	// Results and flags
	output logic      [7:0] result_high_byte_o,
	output logic      [7:0] result_low_byte_o,
	output logic            conv_done_flag_o,
	output logic            window_hit_flag_o
);

	sacc_div_if div_if ();

	sacc_state_e state_q, state_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        on_q, on_d;
	logic        burst_q, burst_d;
	logic        done_q, done_d;
	logic        win_q, win_d;
	logic [2:0]  src_q, src_d;
	logic [7:0]  cfg_q, cfg_d;
	logic [7:0]  res_hi_q, res_hi_d;
	logic [7:0]  res_lo_q, res_lo_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        ext_rise, ctrl_wr, cfg_wr, sw_start;
	logic        trig, start, conv_end, in_window, tick;
	logic [3:0]  conv_last;
	logic        eight, delayed;
	logic        trk_q, trk_d;

	sacc_divider u_div (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.div_if (div_if.div_end)
	);

	sacc_pin_sync u_pin (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.pin_i  (external_convert_pin_i),
		.rise_o (ext_rise)
	);

	assign div_if.burst = burst_q;
	assign div_if.div   = cfg_q[CFG_DIV_LSB +: 5];
	assign div_if.run   = (state_q != ST_IDLE);
	assign tick         = div_if.sar_tick;
	assign eight        = cfg_q[CFG_EIGHT_BIT];
	assign delayed      = cfg_q[CFG_TRACK_BIT];

	// Trigger selection
	always_comb begin
		ctrl_wr  = sfr_wr_i && (sfr_addr_i == CTRL_ADDR);
		cfg_wr   = sfr_wr_i && (sfr_addr_i == CFG_ADDR);
		sw_start = ctrl_wr && sfr_wdata_i[CTRL_BUSY_BIT]
			&& (src_q == SRC_SOFTWARE);
		case (src_q)
			SRC_SOFTWARE: trig = sw_start;
			SRC_TIMER0:   trig = timer0_ovf_i;
			SRC_TIMER2:   trig = timer2_ovf_i;
			SRC_TIMER3:   trig = timer3_ovf_i;
			default:      trig = ext_rise;
		endcase
		start = trig && on_q && (state_q == ST_IDLE);
	end

	// Conversion sequence
	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		conv_end  = 1'b0;
		conv_last = (eight ? CONV_CLKS_8 : CONV_CLKS_10) - 4'h1;
		case (state_q)
			ST_IDLE: begin
				cnt_d = 4'h0;
				if (start) begin
					state_d = delayed ? ST_TRACK : ST_CONV;
				end
			end
			ST_TRACK: begin
				if (tick) begin
					if (cnt_q == TRACK_CLKS - 4'h1) begin
						state_d = ST_CONV;
						cnt_d   = 4'h0;
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
			end
			ST_CONV: begin
				if (tick) begin
					if (cnt_q == conv_last) begin
						state_d  = ST_IDLE;
						cnt_d    = 4'h0;
						conv_end = 1'b1;
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
				cnt_d   = 4'h0;
			end
		endcase
		if (!on_q) begin
			state_d  = ST_IDLE;
			cnt_d    = 4'h0;
			conv_end = 1'b0;
		end
		// Registered so the pin carries no decode glitch
		trk_d = (state_d == ST_TRACK);
	end

	// Result capture and window test
	always_comb begin
		res_hi_d = res_hi_q;
		res_lo_d = res_lo_q;
		if (conv_end) begin
			if (eight) begin
				res_hi_d = sample_data_i[9:2];
				res_lo_d = 8'h00;
			end else begin
				res_hi_d = {6'h00, sample_data_i[9:8]};
				res_lo_d = sample_data_i[7:0];
			end
		end
		in_window = ({res_hi_d, res_lo_d} >= window_lower_bound_i)
			&& ({res_hi_d, res_lo_d} <= window_upper_bound_i);
	end

	// Register writes; hardware sets beat software clears
	always_comb begin
		on_d    = on_q;
		burst_d = burst_q;
		done_d  = done_q;
		win_d   = win_q;
		src_d   = src_q;
		cfg_d   = cfg_q;
		if (ctrl_wr) begin
			on_d    = sfr_wdata_i[CTRL_ON_BIT];
			burst_d = sfr_wdata_i[CTRL_BURST_BIT];
			done_d  = sfr_wdata_i[CTRL_DONE_BIT];
			win_d   = sfr_wdata_i[CTRL_WIN_BIT];
			src_d   = sfr_wdata_i[CTRL_SRC_LSB +: 3];
		end
		if (cfg_wr) begin
			cfg_d = sfr_wdata_i;
		end
		if (conv_end) begin
			done_d = 1'b1;
		end
		if (conv_end && in_window) begin
			win_d = 1'b1;
		end
	end

	// Read data, busy shows a conversion in progress
	always_comb begin
		case (sfr_addr_i)
			CTRL_ADDR: rdata_d = {on_q, burst_q, done_q,
				state_q != ST_IDLE, win_q, src_q};
			CFG_ADDR:  rdata_d = cfg_q;
			default:   rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q  <= ST_IDLE;
			cnt_q    <= 4'h0;
			on_q     <= CTRL_RESET[CTRL_ON_BIT];
			burst_q  <= CTRL_RESET[CTRL_BURST_BIT];
			done_q   <= CTRL_RESET[CTRL_DONE_BIT];
			win_q    <= CTRL_RESET[CTRL_WIN_BIT];
			src_q    <= CTRL_RESET[CTRL_SRC_LSB +: 3];
			cfg_q    <= CFG_RESET;
			res_hi_q <= 8'h00;
			res_lo_q <= 8'h00;
			rdata_q  <= 8'h00;
			trk_q    <= 1'b0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			on_q     <= on_d;
			burst_q  <= burst_d;
			done_q   <= done_d;
			win_q    <= win_d;
			src_q    <= src_d;
			cfg_q    <= cfg_d;
			res_hi_q <= res_hi_d;
			res_lo_q <= res_lo_d;
			rdata_q  <= rdata_d;
			trk_q    <= trk_d;
		end
	end

	assign sfr_rdata_o         = rdata_q;
	assign converter_on_o      = on_q;
	assign tracking_o          = trk_q;
	assign burst_sequence_on_o = burst_q;
	assign input_gain_select_o = cfg_q[CFG_GAIN_BIT];
	assign result_high_byte_o  = res_hi_q;
	assign result_low_byte_o   = res_lo_q;
	assign conv_done_flag_o    = done_q;
	assign window_hit_flag_o   = win_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	off_idle_a: assert property (
		!on_q |=> state_q == ST_IDLE)
		else $error("converter active while disabled");
	burst_bit_a: assert property (
		ctrl_wr |=> burst_q == $past(sfr_wdata_i[CTRL_BURST_BIT]))
		else $error("burst bit not at position six");
	done_set_a: assert property (
		conv_end |=> done_q)
		else $error("done flag missed");
	sw_start_a: assert property (
		ctrl_wr && sfr_wdata_i[CTRL_BUSY_BIT] && src_q == SRC_SOFTWARE
			&& on_q && state_q == ST_IDLE |=> state_q != ST_IDLE)
		else $error("software start lost");
	window_set_a: assert property (
		conv_end && in_window |=> win_q)
		else $error("window flag missed");
	ext_start_a: assert property (
		ext_rise && src_q[2] && on_q && state_q == ST_IDLE
			|=> state_q != ST_IDLE)
		else $error("pin start lost");
	normal_track_a: assert property (
		start && !delayed |=> state_q == ST_CONV)
		else $error("normal track delayed");
	delay_track_a: assert property (
		start && delayed |=> state_q == ST_TRACK
			##1 (state_q == ST_TRACK)[*2])
		else $error("delayed track too short");
	eight_low_a: assert property (
		conv_end && eight |=> res_lo_q == 8'h00)
		else $error("low byte not zero");
	flag_hold_a: assert property (
		done_q && !ctrl_wr |=> done_q)
		else $error("done flag cleared by hardware");
	off_ignore_a: assert property (
		!on_q && !ctrl_wr |=> done_q == $past(done_q))
		else $error("flag changed while disabled");

	conv_done_c: cover property (conv_end && !eight);
	window_hit_c: cover property (conv_end && in_window);
	delayed_c: cover property (start && delayed ##[1:600] conv_end);
	burst_c: cover property (conv_end && burst_q);
	pin_start_c: cover property (start && src_q[2]);

endmodule // sacc_core

`default_nettype wire

//--- testbench/sacc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_host_model (
	// Clock
	input  wire logic clk_i,
	// Start sources seen by the converter
	output logic      timer0_ovf_o,
	output logic      timer2_ovf_o,
	output logic      timer3_ovf_o,
	output logic      ext_pin_o
);
	initial begin
		timer0_ovf_o = 1'b0;
		timer2_ovf_o = 1'b0;
		timer3_ovf_o = 1'b0;
		ext_pin_o    = 1'b0;
	end

	task automatic fire(input int k);
		@(posedge clk_i);
		case (k)
			1: timer0_ovf_o <= 1'b1;
			2: timer2_ovf_o <= 1'b1;
			3: timer3_ovf_o <= 1'b1;
			default: ext_pin_o <= 1'b1;
		endcase
		@(posedge clk_i);
		{timer0_ovf_o, timer2_ovf_o, timer3_ovf_o} <= 3'h0;
		// Pin held past the synchroniser, else the edge is lost
		repeat (3) @(posedge clk_i);
		ext_pin_o <= 1'b0;
	endtask
endmodule // sacc_host_model

`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top import sacc_pkg::*;;
	logic        clk_i, srst_i, wr, t0, t2, t3, pin;
	logic        on, trk, gain, bst, done, win;
	logic [7:0]  addr, wdata, rdata, rh, rl;
	logic [9:0]  smp;
	logic [15:0] lo_b, hi_b;
	int          n_mismatch = 0;
	int          compares = 0;

	sacc_core u_dut (
		.clk_i(clk_i), .srst_i(srst_i),
		.sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata),
		.sfr_rdata_o(rdata),
		.timer0_ovf_i(t0), .timer2_ovf_i(t2), .timer3_ovf_i(t3),
		.external_convert_pin_i(pin), .sample_data_i(smp),
		.converter_on_o(on), .tracking_o(trk),
		.input_gain_select_o(gain), .burst_sequence_on_o(bst),
		.window_lower_bound_i(lo_b), .window_upper_bound_i(hi_b),
		.result_high_byte_o(rh), .result_low_byte_o(rl),
		.conv_done_flag_o(done), .window_hit_flag_o(win)
	);

	sacc_host_model u_host (
		.clk_i(clk_i), .timer0_ovf_o(t0), .timer2_ovf_o(t2),
		.timer3_ovf_o(t3), .ext_pin_o(pin)
	);

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_in(input int got, input int lo, input int hi);
		compares++;
		if (got < lo || got > hi) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, lo);
		end
	endtask

	task automatic end_of_test;
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		repeat (2) @(posedge clk_i);
		#1;
		d = rdata;
	endtask

	// Bounded wait, a hang ends the run
	task automatic wait_done(output int n, output logic t);
		n = 0;
		t = 1'b0;
		while (done !== 1'b1) begin
			@(posedge clk_i);
			#1;
			n++;
			if (trk === 1'b1)
				t = 1'b1;
			if (n > 3000) begin
				chk(16'h0000, 16'h0001);
				end_of_test;
			end
		end
	endtask

	task automatic conv(input logic [7:0] cfg, input logic [7:0] ctl,
		input int per, input int ticks, input logic [15:0] res,
		input logic w);
		int n;
		logic t;
		logic [7:0] r;
		wr_reg(CFG_ADDR, cfg);
		// Enable and source first: a busy write sees the old source
		wr_reg(CTRL_ADDR, ctl & 8'hef);
		wr_reg(CTRL_ADDR, ctl);
		wait_done(n, t);
		// First SAR clock may be partial against the free oscillator
		chk_in(n, per * (ticks - 1) + 1, per * ticks + 1);
		chk(16'(t), 16'(cfg[CFG_TRACK_BIT]));
		chk({rh, rl}, res);
		chk(16'(win), 16'(w));
		rd_reg(CTRL_ADDR, r);
		chk(16'(r), 16'((ctl & 8'hc7) | 8'h20 | {4'h0, w, 3'h0}));
		wr_reg(CTRL_ADDR, ctl & 8'hc7);
		rd_reg(CTRL_ADDR, r);
		chk(16'(r), 16'(ctl & 8'hc7));
	endtask

	task automatic t_reset;
		logic [7:0] r;
		rd_reg(CTRL_ADDR, r);
		chk(16'(r), 16'(CTRL_RESET));
		rd_reg(CFG_ADDR, r);
		chk(16'(r), 16'(CFG_RESET));
		rd_reg(8'h00, r);
		chk(16'(r), 16'h0000);
		chk(16'({on, bst, gain}), 16'h0001);
		$display("test reset done");
	endtask

	task automatic t_off;
		wr_reg(CTRL_ADDR, 8'h10);
		repeat (40) @(posedge clk_i);
		chk(16'({on, done}), 16'h0000);
		wr_reg(CTRL_ADDR, 8'h01);
		u_host.fire(1);
		repeat (40) @(posedge clk_i);
		chk(16'({done, win}), 16'h0000);
		chk({rh, rl}, 16'h0000);
		$display("test off done");
	endtask

	task automatic t_gain;
		wr_reg(CFG_ADDR, 8'h01);
		#1;
		chk(16'(gain), 16'h0001);
		wr_reg(CFG_ADDR, 8'h00);
		#1;
		chk(16'(gain), 16'h0000);
		$display("test gain done");
	endtask

	task automatic t_modes;
		@(posedge clk_i);
		smp <= 10'h2a5;
		lo_b <= 16'h02a5;
		hi_b <= 16'h02a5;
		conv(8'h00, 8'h90, 1, 13, 16'h02a5, 1'b1);
		lo_b <= 16'h02a6;
		hi_b <= 16'hffff;
		conv(8'h10, 8'h90, 3, 13, 16'h02a5, 1'b0);
		smp <= 10'h2a7;
		lo_b <= 16'h0000;
		conv(8'h06, 8'h90, 1, 14, 16'ha900, 1'b1);
		conv(8'h00, 8'hd0, 10, 13, 16'h02a7, 1'b1);
		chk(16'(bst), 16'h0001);
		wr_reg(CTRL_ADDR, 8'h80);
		$display("test modes done");
	endtask

	task automatic t_src;
		int n;
		logic t;
		for (int s = 1; s <= 4; s++) begin
			wr_reg(CTRL_ADDR, 8'h80 | 8'(s));
			u_host.fire(s % 4 + 1);
			repeat (20) @(posedge clk_i);
			chk(16'(done), 16'h0000);
			u_host.fire(s);
			wait_done(n, t);
			chk({rh, rl}, 16'h02a7);
			wr_reg(CTRL_ADDR, 8'h80 | 8'(s));
		end
		$display("test sources done");
	endtask

	task automatic t_abort;
		logic [7:0] r;
		wr_reg(CFG_ADDR, 8'hf8);
		wr_reg(CTRL_ADDR, 8'h80);
		wr_reg(CTRL_ADDR, 8'h90);
		repeat (20) @(posedge clk_i);
		rd_reg(CTRL_ADDR, r);
		chk(16'(r), 16'h0090);
		wr_reg(CTRL_ADDR, 8'h00);
		repeat (500) @(posedge clk_i);
		chk(16'({on, done}), 16'h0000);
		$display("test abort done");
	endtask

	initial begin
		srst_i = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		smp = 10'h000;
		lo_b = 16'h0000;
		hi_b = 16'h0000;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		t_reset;
		t_off;
		t_gain;
		t_modes;
		t_src;
		t_abort;
		end_of_test;
	end
endmodule // tb_top

`default_nettype wire
